// file: verilog/ledg_pkg.sv
/*
 * Constants and types for the I/O-check LED display block: bit map of the
 * terminal words, segment order, glyph table, menu codes and blink timing.
 * Assumes one system clock at the rate given by CLK_PERIOD_NS.
 */
`default_nettype none

package ledg_pkg;

    // clock and blink timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BLINK_HALF_NS = 250_000_000;
    // longest half period, so rounds down
    localparam int BLINK_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam int BLINK_CNT_W = 22;

    // bit positions of the input word
    localparam int IN_FWD_BIT = 0;
    localparam int IN_REV_BIT = 1;
    localparam int IN_GEN_LSB = 2;
    localparam int IN_XF_BIT = 13;
    localparam int IN_XR_BIT = 14;
    localparam int IN_RST_BIT = 15;

    // bit positions of the output word
    localparam int OUT_TR_BIT = 0;
    localparam int OUT_RELAY_BIT = 8;

    // segment bit positions inside one digit
    localparam int SEG_A = 0;
    localparam int SEG_G = 6;
    localparam int SEG_DP = 7;

    // pin vector layout (terminal senses, jumper, keys)
    localparam int PIN_W = 13;
    localparam int PIN_TR = 5;
    localparam int PIN_RELAY = 6;
    localparam int PIN_SOURCE = 7;
    localparam int KEY_LSB = 8;
    localparam int KEY_PROG = 0;
    localparam int KEY_UP = 1;
    localparam int KEY_DOWN = 2;
    localparam int KEY_ENTER = 3;
    localparam int KEY_BACK = 4;

    // menu and item codes
    localparam logic [2:0] MENU_FIRST = 3'h1;
    localparam logic [2:0] MENU_LAST = 3'h6;
    localparam logic [2:0] MENU_IO = 3'h4;
    localparam logic [2:0] MENU_RESET = 3'h1;
    localparam logic [1:0] SCOPE_FULL = 2'h2;
    localparam logic [2:0] ITEM_TERM = 3'h0;
    localparam logic [2:0] ITEM_COMM = 3'h1;
    localparam logic [2:0] ITEM_LAST = 3'h4;
    localparam logic [3:0] ITEM_GROUP = 4'h4;

    // special glyphs, bit order dp g f e d c b a
    localparam logic [7:0] GLYPH_BLANK = 8'h00;
    localparam logic [7:0] GLYPH_DASH = 8'h40;
    localparam logic [7:0] GLYPH_UNDER = 8'h08;

    // hex glyphs 0..9 A b C d E F, lower-case shapes for b and d
    localparam logic [7:0] SEG_GLYPH [16] = '{
        8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
        8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71
    };

    typedef enum logic [1:0] {ST_RUN, ST_MENU, ST_LIST, ST_DATA} ledg_state_t;

endpackage

`default_nettype wire

// file: verilog/ledg_hex_glyph.sv
/*
 * One nibble to one seven-segment hex glyph, purely combinational.
 * Assumes the caller registers the result before it reaches a pin.
 */
`timescale 1ns/1ps
`default_nettype none

module ledg_hex_glyph (
    // nibble in
    input wire logic [3:0] nibble,
    // segments out, dp g f e d c b a
    output logic [7:0] segs
);

    // table lookup keeps b and d lower case
    assign segs = ledg_pkg::SEG_GLYPH[nibble];

endmodule

`default_nettype wire

// file: verilog/ledg_io_display.sv
/*
 * I/O-check LED display: menu walk from Running mode to items 4_00/4_01,
 * terminal words, segment and hex formats, four registered digit outputs.
 * Assumes pins and keys are asynchronous levels; comm and setting inputs
 * come from logic on the same clock. Key inputs are high while pressed.
 */
//
// Contract
// - nibble becomes hex glyph, lower b d
// - two formats, segments or hex word
// - digit1 a-e show five run and general inputs
// - digit3 segment a shows transistor output
// - digit4 segment a shows relay make contact
// - all inputs off blinks g everywhere
// - hex word, high nibble on left digit
// - unassigned word bits read zero
// - forward bit0, reverse bit1 in input word
// - general inputs 1-3 at bits 2-4
// - closed to active common reads one
// - transistor output at output bit0
// - relay make contact at output bit8
// - comm commands at input bits 13-15
// - reset into Running, key enters Programming
// - enter on I/O menu lists from 4_00
// - item 4_00 shows physical terminals
// - item 4_01 shows link commands
// - back returns to list, then menu
// - link commands shown non-inverted
`timescale 1ns/1ps
`default_nettype none

module ledg_io_display #(
    parameter int BlinkCycles = ledg_pkg::BLINK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // terminal pins; run and general inputs are low while closed unless sourceJumper is high
    input wire logic forwardRunInput,
    input wire logic reverseRunInput,
    input wire logic generalInput1,
    input wire logic generalInput2,
    input wire logic generalInput3,
    input wire logic transistorOutput,
    input wire logic relayContactOutput,
    input wire logic sourceJumper,
    // keypad pins
    input wire logic keyProgram,
    input wire logic keyUp,
    input wire logic keyDown,
    input wire logic keyEnter,
    input wire logic keyBack,
    // link commands from the comm receiver
    input wire logic commForwardRun,
    input wire logic commReverseRun,
    input wire logic commGeneral1,
    input wire logic commGeneral2,
    input wire logic commGeneral3,
    input wire logic commForwardCmd,
    input wire logic commReverseCmd,
    input wire logic commResetCmd,
    // settings
    input wire logic [1:0] menuScopeSetting,
    input wire logic hexMode,
    // display and status
    output logic [7:0] digit1Seg,
    output logic [7:0] digit2Seg,
    output logic [7:0] digit3Seg,
    output logic [7:0] digit4Seg,
    output logic programMode
);

    typedef struct packed {
        ledg_pkg::ledg_state_t state;
        logic [2:0] menuSel;
        logic [2:0] itemSel;
        logic showOut;
        logic [ledg_pkg::BLINK_CNT_W-1:0] blinkCnt;
        logic blinkOn;
        logic [ledg_pkg::PIN_W-1:0] pinMeta;
        logic [ledg_pkg::PIN_W-1:0] pinSync;
        logic [4:0] keyPrev;
        logic [7:0] dig1;
        logic [7:0] dig2;
        logic [7:0] dig3;
        logic [7:0] dig4;
    } ledg_regs_t;

    localparam ledg_regs_t REG_RESET = '{
        state: ledg_pkg::ST_RUN,
        menuSel: ledg_pkg::MENU_RESET,
        default: '0
    };
    localparam logic [ledg_pkg::BLINK_CNT_W-1:0] BLINK_LIM =
        ledg_pkg::BLINK_CNT_W'(BlinkCycles - 1);

    ledg_regs_t cur;
    ledg_regs_t nxt;
    logic [ledg_pkg::PIN_W-1:0] pinRaw;
    logic [4:0] termClosed;
    logic [4:0] keyLvl;
    logic [4:0] keyHit;
    logic [15:0] physInWord;
    logic [15:0] commInWord;
    logic [15:0] outWord;
    logic [15:0] inWord;
    logic [15:0] shownWord;
    logic [15:0] dispWord;
    logic [7:0] glyph [4];
    logic ioItem;
    logic allOff;

    // packs the input word; used for both physical and link items
    function automatic logic [15:0] mkInWord(input logic [4:0] term, input logic xf,
                                            input logic xr, input logic rst);
        logic [15:0] w;
        w = '0; // free bits stay zero
        w[ledg_pkg::IN_FWD_BIT] = term[0];
        w[ledg_pkg::IN_REV_BIT] = term[1];
        w[ledg_pkg::IN_GEN_LSB +: 3] = term[4:2];
        w[ledg_pkg::IN_XF_BIT] = xf;
        w[ledg_pkg::IN_XR_BIT] = xr;
        w[ledg_pkg::IN_RST_BIT] = rst;
        return w;
    endfunction

    // raw pin vector, synchronised in the state struct
    assign pinRaw = {keyBack, keyEnter, keyDown, keyUp, keyProgram, sourceJumper,
                     relayContactOutput, transistorOutput, generalInput3, generalInput2,
                     generalInput1, reverseRunInput, forwardRunInput};

    // sink pulls a closed input low, source pulls it high
    assign termClosed = cur.pinSync[ledg_pkg::PIN_SOURCE] ? cur.pinSync[4:0]
                                                          : ~cur.pinSync[4:0];
    assign keyLvl = cur.pinSync[ledg_pkg::KEY_LSB +: 5];
    assign keyHit = keyLvl & ~cur.keyPrev; // press edge, one cycle

    // terminal words; physical item has no comm bits
    assign physInWord = mkInWord(termClosed, 1'b0, 1'b0, 1'b0);
    // link commands taken as sent, no sink/source inversion
    assign commInWord = mkInWord({commGeneral3, commGeneral2, commGeneral1,
                                  commReverseRun, commForwardRun},
                                 commForwardCmd, commReverseCmd, commResetCmd);

    // output word
    always_comb begin
        outWord = '0;
        outWord[ledg_pkg::OUT_TR_BIT] = cur.pinSync[ledg_pkg::PIN_TR];
        outWord[ledg_pkg::OUT_RELAY_BIT] = cur.pinSync[ledg_pkg::PIN_RELAY];
    end

    assign ioItem = (cur.itemSel == ledg_pkg::ITEM_TERM) || (cur.itemSel == ledg_pkg::ITEM_COMM);
    assign inWord = (cur.itemSel == ledg_pkg::ITEM_COMM) ? commInWord : physInWord;
    assign shownWord = cur.showOut ? outWord : inWord;
    assign allOff = (inWord == 16'h0000);

    // nibbles fed to the glyph encoders depend on the screen
    always_comb begin
        case (cur.state)
            ledg_pkg::ST_MENU: dispWord = {13'h0000, cur.menuSel};
            ledg_pkg::ST_LIST: dispWord = {ledg_pkg::ITEM_GROUP, 8'h00, 1'b0, cur.itemSel};
            default: dispWord = shownWord;
        endcase
    end

    // left digit takes the top nibble
    for (genvar g = 0; g < 4; g++) begin : gen_glyph
        ledg_hex_glyph u_glyph (
            .nibble(dispWord[4*g +: 4]),
            .segs(glyph[g])
        );
    end

    // next state of everything
    always_comb begin
        nxt = cur;
        nxt.pinMeta = pinRaw;
        nxt.pinSync = cur.pinMeta;
        nxt.keyPrev = keyLvl;

        // free-running blink divider
        if (cur.blinkCnt >= BLINK_LIM) begin
            nxt.blinkCnt = '0;
            nxt.blinkOn = ~cur.blinkOn;
        end else begin
            nxt.blinkCnt = cur.blinkCnt + 1'b1;
        end

        // menu walk; program key wins over all others
        case (cur.state)
            ledg_pkg::ST_RUN: begin
                if (keyHit[ledg_pkg::KEY_PROG]) begin
                    nxt.state = ledg_pkg::ST_MENU;
                    nxt.menuSel = ledg_pkg::MENU_RESET;
                end
            end
            ledg_pkg::ST_MENU: begin
                if (keyHit[ledg_pkg::KEY_PROG] || keyHit[ledg_pkg::KEY_BACK]) begin
                    nxt.state = ledg_pkg::ST_RUN;
                end else if (keyHit[ledg_pkg::KEY_ENTER]) begin
                    // item list only in full-menu scope
                    if (cur.menuSel == ledg_pkg::MENU_IO
                        && menuScopeSetting == ledg_pkg::SCOPE_FULL) begin
                        nxt.state = ledg_pkg::ST_LIST;
                        nxt.itemSel = ledg_pkg::ITEM_TERM;
                    end
                end else if (keyHit[ledg_pkg::KEY_UP]) begin
                    nxt.menuSel = (cur.menuSel == ledg_pkg::MENU_LAST) ? ledg_pkg::MENU_FIRST
                                                                       : cur.menuSel + 3'h1;
                end else if (keyHit[ledg_pkg::KEY_DOWN]) begin
                    nxt.menuSel = (cur.menuSel == ledg_pkg::MENU_FIRST) ? ledg_pkg::MENU_LAST
                                                                        : cur.menuSel - 3'h1;
                end
            end
            ledg_pkg::ST_LIST: begin
                if (keyHit[ledg_pkg::KEY_PROG]) begin
                    nxt.state = ledg_pkg::ST_RUN;
                end else if (keyHit[ledg_pkg::KEY_BACK]) begin
                    nxt.state = ledg_pkg::ST_MENU;
                end else if (keyHit[ledg_pkg::KEY_ENTER]) begin
                    nxt.state = ledg_pkg::ST_DATA;
                    nxt.showOut = 1'b0;
                end else if (keyHit[ledg_pkg::KEY_UP]) begin
                    nxt.itemSel = (cur.itemSel == ledg_pkg::ITEM_LAST) ? ledg_pkg::ITEM_TERM
                                                                       : cur.itemSel + 3'h1;
                end else if (keyHit[ledg_pkg::KEY_DOWN]) begin
                    nxt.itemSel = (cur.itemSel == ledg_pkg::ITEM_TERM) ? ledg_pkg::ITEM_LAST
                                                                       : cur.itemSel - 3'h1;
                end
            end
            ledg_pkg::ST_DATA: begin
                if (keyHit[ledg_pkg::KEY_PROG]) begin
                    nxt.state = ledg_pkg::ST_RUN;
                end else if (keyHit[ledg_pkg::KEY_BACK]) begin
                    nxt.state = ledg_pkg::ST_LIST;
                end else if (keyHit[ledg_pkg::KEY_UP] || keyHit[ledg_pkg::KEY_DOWN]) begin
                    nxt.showOut = ~cur.showOut; // hex view flips in/out word
                end
            end
            default: nxt.state = ledg_pkg::ST_RUN;
        endcase

        // digit patterns, registered so the pins never glitch
        nxt.dig1 = glyph[0];
        nxt.dig2 = glyph[1];
        nxt.dig3 = glyph[2];
        nxt.dig4 = glyph[3];
        case (cur.state)
            ledg_pkg::ST_RUN: begin
                nxt.dig1 = ledg_pkg::GLYPH_DASH;
                nxt.dig2 = ledg_pkg::GLYPH_DASH;
                nxt.dig3 = ledg_pkg::GLYPH_DASH;
                nxt.dig4 = ledg_pkg::GLYPH_DASH;
            end
            ledg_pkg::ST_MENU: begin
                nxt.dig2 = ledg_pkg::GLYPH_BLANK;
                nxt.dig3 = ledg_pkg::GLYPH_BLANK;
                nxt.dig4 = ledg_pkg::GLYPH_BLANK;
            end
            ledg_pkg::ST_LIST: nxt.dig3 = ledg_pkg::GLYPH_UNDER; // "4_0n"
            ledg_pkg::ST_DATA: begin
                if (!ioItem) begin
                    // analog items are not served here
                    nxt.dig1 = ledg_pkg::GLYPH_DASH;
                    nxt.dig2 = ledg_pkg::GLYPH_DASH;
                    nxt.dig3 = ledg_pkg::GLYPH_DASH;
                    nxt.dig4 = ledg_pkg::GLYPH_DASH;
                end else if (!hexMode) begin // format picked by a pin
                    if (allOff) begin
                        // blink g on every digit instead
                        nxt.dig1 = cur.blinkOn ? ledg_pkg::GLYPH_DASH : ledg_pkg::GLYPH_BLANK;
                        nxt.dig2 = nxt.dig1;
                        nxt.dig3 = nxt.dig1;
                        nxt.dig4 = nxt.dig1;
                    end else begin
                        // dp g f = RST XR XF, e..a = inputs
                        nxt.dig1 = {inWord[ledg_pkg::IN_RST_BIT], inWord[ledg_pkg::IN_XR_BIT],
                                    inWord[ledg_pkg::IN_XF_BIT], inWord[4:0]};
                        nxt.dig2 = ledg_pkg::GLYPH_BLANK;
                        nxt.dig3 = {7'h00, outWord[ledg_pkg::OUT_TR_BIT]};
                        nxt.dig4 = {7'h00, outWord[ledg_pkg::OUT_RELAY_BIT]};
                    end
                end
            end
            default: nxt.dig1 = ledg_pkg::GLYPH_BLANK;
        endcase
    end

    // one register bank for the whole block
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cur <= REG_RESET; // comes up in Running mode
        end else begin
            cur <= nxt;
        end
    end

    assign digit1Seg = cur.dig1;
    assign digit2Seg = cur.dig2;
    assign digit3Seg = cur.dig3;
    assign digit4Seg = cur.dig4;
    assign programMode = (cur.state != ledg_pkg::ST_RUN);

    property p_enter_prog;
        @(posedge clock) disable iff (!rst_b)
        (cur.state == ledg_pkg::ST_RUN) && keyHit[ledg_pkg::KEY_PROG]
        |=> programMode ##1 digit1Seg == ledg_pkg::SEG_GLYPH[ledg_pkg::MENU_RESET];
    endproperty
    a_enter_prog: assert property (p_enter_prog) else $error("program key did not open menu");

    property p_open_list;
        @(posedge clock) disable iff (!rst_b)
        (cur.state == ledg_pkg::ST_MENU) && keyHit[4:2] == 3'b010 && !keyHit[ledg_pkg::KEY_PROG]
        && cur.menuSel == ledg_pkg::MENU_IO && menuScopeSetting == ledg_pkg::SCOPE_FULL
        |=> cur.state == ledg_pkg::ST_LIST && cur.itemSel == 3'h0 ##1 digit3Seg == ledg_pkg::GLYPH_UNDER;
    endproperty
    a_open_list: assert property (p_open_list) else $error("I/O list did not open at item 0");

    property p_scope_gate;
        @(posedge clock) disable iff (!rst_b)
        (cur.state == ledg_pkg::ST_MENU) && menuScopeSetting != ledg_pkg::SCOPE_FULL
        |=> cur.state != ledg_pkg::ST_LIST;
    endproperty
    a_scope_gate: assert property (p_scope_gate) else $error("list opened outside full scope");

    property p_back_walk;
        @(posedge clock) disable iff (!rst_b)
        (cur.state == ledg_pkg::ST_DATA) && keyHit[ledg_pkg::KEY_BACK] && !keyHit[ledg_pkg::KEY_PROG]
        |=> cur.state == ledg_pkg::ST_LIST;
    endproperty
    a_back_walk: assert property (p_back_walk) else $error("back key did not return to list");

    property p_hex_left;
        @(posedge clock) disable iff (!rst_b)
        (cur.state == ledg_pkg::ST_DATA) && hexMode && ioItem
        |=> digit4Seg == ledg_pkg::SEG_GLYPH[$past(shownWord[15:12])]
            && digit1Seg == ledg_pkg::SEG_GLYPH[$past(shownWord[3:0])];
    endproperty
    a_hex_left: assert property (p_hex_left) else $error("hex digits out of order");

    property p_seg_fwd;
        @(posedge clock) disable iff (!rst_b)
        (cur.state == ledg_pkg::ST_DATA) && !hexMode && cur.itemSel == ledg_pkg::ITEM_TERM && !allOff
        |=> digit1Seg[ledg_pkg::SEG_A] == $past(termClosed[0])
            && digit4Seg[ledg_pkg::SEG_A] == $past(cur.pinSync[ledg_pkg::PIN_RELAY]);
    endproperty
    a_seg_fwd: assert property (p_seg_fwd) else $error("segment a does not track terminal");

    property p_blink_all;
        @(posedge clock) disable iff (!rst_b)
        (cur.state == ledg_pkg::ST_DATA) && !hexMode && ioItem && allOff
        |=> digit1Seg == {1'b0, $past(cur.blinkOn), 6'h00} && digit4Seg == digit1Seg;
    endproperty
    a_blink_all: assert property (p_blink_all) else $error("idle segment g blink wrong");

    property p_blink_rate;
        @(posedge clock) disable iff (!rst_b)
        $changed(cur.blinkOn) |-> $past(cur.blinkCnt) == BLINK_LIM && cur.blinkCnt == '0;
    endproperty
    a_blink_rate: assert property (p_blink_rate) else $error("blink toggled off count");

    property p_comm_bits;
        @(posedge clock) disable iff (!rst_b)
        commInWord[15:13] == {commResetCmd, commReverseCmd, commForwardCmd}
        && physInWord[15:5] == 11'h000;
    endproperty
    a_comm_bits: assert property (p_comm_bits) else $error("comm command bits misplaced");

endmodule

`default_nettype wire

// file: testbench/ledg_term_model.sv
/*
 * Far-side model: terminal contacts and the keypad operator's setting.
 * Assumes the bench supplies which contacts are closed and the jumper.
 */
`timescale 1ns/1ps
`default_nettype none

module ledg_term_model (
    // closures from the bench
    input wire logic [4:0] closed,
    input wire logic sourceJumper,
    input wire logic operatorReady,
    // pins and setting to the block
    output logic [4:0] pinLevel,
    output logic [1:0] menuScope
);
    // sink pulls closed pins low, source drives them high
    assign pinLevel = sourceJumper ? closed : ~closed;
    // operator picks full menu only once ready, so early entry is refused
    assign menuScope = operatorReady ? ledg_pkg::SCOPE_FULL : 2'h1;
endmodule

`default_nettype wire

// file: testbench/tb.sv
/*
 * Self-checking bench for the I/O-check display: key walk, hex and
 * segment formats, blink. Assumes ledg_pkg and the terminal model.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end

module tb;
    localparam int Blink = 8;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] closed = 5'h0;
    logic [4:0] pins;
    logic jumper = 1'b0;
    logic ready = 1'b1;
    logic tr = 1'b0;
    logic relay = 1'b0;
    logic [4:0] keys = 5'h0; // back enter down up program
    logic [7:0] comm = 8'h00; // rst xr xf g3 g2 g1 rev fwd
    logic hex = 1'b1;
    logic [1:0] scope;
    logic [7:0] d1, d2, d3, d4;
    logic pm;
    logic [32:0] q[$];
    logic [32:0] want;
    int fails = 0;
    int tests_run = 0;
    int seed = 47;
    int n40, n00;

    always #50 clock = ~clock;

    ledg_term_model model (.closed(closed), .sourceJumper(jumper), .operatorReady(ready),
        .pinLevel(pins), .menuScope(scope));

    ledg_io_display #(.BlinkCycles(Blink)) dut (.clock(clock), .rst_b(rst_b),
        .forwardRunInput(pins[0]), .reverseRunInput(pins[1]), .generalInput1(pins[2]),
        .generalInput2(pins[3]), .generalInput3(pins[4]), .transistorOutput(tr),
        .relayContactOutput(relay), .sourceJumper(jumper), .keyProgram(keys[0]),
        .keyUp(keys[1]), .keyDown(keys[2]), .keyEnter(keys[3]), .keyBack(keys[4]),
        .commForwardRun(comm[0]), .commReverseRun(comm[1]), .commGeneral1(comm[2]),
        .commGeneral2(comm[3]), .commGeneral3(comm[4]), .commForwardCmd(comm[5]),
        .commReverseCmd(comm[6]), .commResetCmd(comm[7]), .menuScopeSetting(scope),
        .hexMode(hex), .digit1Seg(d1), .digit2Seg(d2), .digit3Seg(d3), .digit4Seg(d4),
        .programMode(pm));

    // four glyphs of a word, high nibble on the left digit
    function automatic logic [31:0] hexs(input logic [15:0] v);
        hexs = {ledg_pkg::SEG_GLYPH[v[15:12]], ledg_pkg::SEG_GLYPH[v[11:8]],
            ledg_pkg::SEG_GLYPH[v[7:4]], ledg_pkg::SEG_GLYPH[v[3:0]]};
    endfunction

    // let pins pass the synchronisers, then leave the expectation
    task automatic note(input logic p, input logic [31:0] segs);
        repeat (5) @(negedge clock);
        q.push_back({p, segs});
        wait (q.size() == 0);
    endtask

    // one clean press: rise, hold, then low long enough for the next edge
    task automatic press(input int k);
        @(negedge clock);
        keys[k] = 1'b1;
        repeat (3) @(negedge clock);
        keys[k] = 1'b0;
        repeat (3) @(negedge clock);
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // takes the oldest note once the screen has settled
    always begin
        wait (q.size() > 0);
        @(negedge clock);
        want = q.pop_front();
        `CHK({pm, d4, d3, d2, d1}, want)
    end

    // main sequence, inputs change at the falling edge
    initial begin
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        note(1'b0, 32'h40404040);
        press(0);
        note(1'b1, 32'h00000006);
        press(3);
        note(1'b1, 32'h00000006);
        repeat (3) press(1);
        ready = 1'b0;
        press(3);
        note(1'b1, 32'h00000066);
        ready = 1'b1;
        press(3);
        note(1'b1, 32'h66083f3f);
        press(3);
        // item 0 must keep comm bits out of the word
        for (int i = 0; i < 6; i++) begin
            {comm, relay, tr, jumper, closed} = 16'($random(seed));
            note(1'b1, hexs({11'h0, closed}));
            press(1);
            note(1'b1, hexs({7'h0, relay, 7'h0, tr}));
            press(2);
        end
        hex = 1'b0;
        // never all off here, so no blink
        for (int i = 0; i < 4; i++) begin
            {relay, tr, closed} = 7'($random(seed)) | 7'h01;
            note(1'b1, {7'h0, relay, 7'h0, tr, 8'h00, 3'h0, closed});
        end
        // outputs on but inputs off: blink still expected
        closed = 5'h0;
        tr = 1'b1;
        n40 = 0;
        n00 = 0;
        repeat (5) @(negedge clock);
        repeat (4 * Blink) begin
            @(negedge clock);
            if ({d4, d3, d2, d1} === 32'h40404040) n40++;
            else if ({d4, d3, d2, d1} === 32'h0) n00++;
        end
        `CHK(n40, 2 * Blink)
        `CHK(n00, 2 * Blink)
        press(4);
        note(1'b1, 32'h66083f3f);
        press(1);
        note(1'b1, 32'h66083f06);
        press(3);
        hex = 1'b1;
        for (int i = 0; i < 4; i++) begin
            comm = 8'($random(seed));
            note(1'b1, hexs({comm[7:5], 8'h0, comm[4:0]}));
        end
        hex = 1'b0;
        comm = 8'hb5;
        note(1'b1, {7'h0, relay, 7'h0, tr, 8'h00, comm});
        press(4);
        note(1'b1, 32'h66083f06);
        // down wraps below item 0 to the last item, which shows dashes
        repeat (2) press(2);
        note(1'b1, 32'h66083f66);
        press(3);
        note(1'b1, 32'h40404040);
        press(4);
        press(1);
        note(1'b1, 32'h66083f3f);
        press(4);
        note(1'b1, 32'h00000066);
        press(0);
        note(1'b0, 32'h40404040);
        results();
    end

    // watchdog, far beyond the expected run of about five hundred cycles
    initial begin
        #1_000_000;
        fails++;
        results();
    end
endmodule

`default_nettype wire
